// >>> src/tea_pkg.sv
// constants shared by both ends of the entry access link
// assumes one clock and an active low asynchronous reset
package tea_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int DATA_W    = 32;
   localparam int VPN_W     = 20;
   localparam int PID_MAX_W = 14;
   localparam int WAY_F_W   = 4;
   localparam int WAY_MAX   = 16;
   localparam int ENT_W     = 25;
   localparam int PFN_W     = 20;
   // ------------------------------------------------------------
   // entry data word
   // ------------------------------------------------------------
   localparam int ENT_C     = 24;
   localparam int ENT_R     = 23;
   localparam int ENT_W_B   = 22;
   localparam int ENT_X     = 21;
   localparam int ENT_G     = 20;
   // ------------------------------------------------------------
   // misc control word
   // ------------------------------------------------------------
   localparam int MISC_WAY  = 20;
   localparam int MISC_RD   = 19;
   localparam int MISC_WE   = 18;
   localparam int MISC_PID  = 4;
   localparam int MISC_DBL  = 3;
   localparam int MISC_BAD  = 2;
   localparam int MISC_PERM = 1;
   localparam int MISC_D    = 0;
   // ------------------------------------------------------------
   // virtual page word
   // ------------------------------------------------------------
   localparam int VPG_LO    = 2;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {
      SEL_ENTRY = 2'h0,
      SEL_MISC  = 2'h1,
      SEL_VPAGE = 2'h2
   } tea_sel_t;
   // ------------------------------------------------------------
   // host apb map
   // ------------------------------------------------------------
   localparam logic [11:0] HOST_CMD   = 12'h000;
   localparam logic [11:0] HOST_WDATA = 12'h004;
   localparam logic [11:0] HOST_RDATA = 12'h008;
   localparam logic [11:0] HOST_STAT  = 12'h00C;
   localparam int CMD_WR = 8;
endpackage

// >>> src/tea_ctl_if.sv
// control register link between core end and entry access end
// assumes both ends share clk_i and rst_n_i
`timescale 1ns/1ns
`default_nettype none
interface tea_ctl_if;
   import tea_pkg::*;
   logic              req;
   logic              we;
   tea_sel_t          sel;
   logic [DATA_W-1:0] wdata;
   logic              ack;
   logic [DATA_W-1:0] rdata;
   modport dev (input req, input we, input sel, input wdata,
                output ack, output rdata);
   modport core (output req, output we, output sel, output wdata,
                 input ack, input rdata);
endinterface
`default_nettype wire

// >>> src/tea_entry_store.sv
// flip-flop storage of translation entries with lookup
// assumes line and way given by the owner, index built inside from them
`timescale 1ns/1ns
`default_nettype none
module tea_entry_store
   import tea_pkg::*;
#(
   parameter int LINES = 16,
   parameter int WAYS  = 16,
   parameter int TAG_W = 16,
   parameter int PID_W = 14
)(
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     wr_i,
   input  wire logic [$clog2(LINES)-1:0] wr_line_i,
   input  wire logic [WAY_F_W-1:0]       wr_way_i,
   input  wire logic [TAG_W-1:0]         wr_tag_i,
   input  wire logic [PID_W-1:0]         wr_pid_i,
   input  wire logic [ENT_W-1:0]         wr_ent_i,
   input  wire logic [$clog2(LINES)-1:0] rd_line_i,
   input  wire logic [WAY_F_W-1:0]       rd_way_i,
   output logic [TAG_W-1:0]              rd_tag_o,
   output logic [PID_W-1:0]              rd_pid_o,
   output logic [ENT_W-1:0]              rd_ent_o,
   input  wire logic [$clog2(LINES)-1:0] lk_line_i,
   input  wire logic [TAG_W-1:0]         lk_tag_i,
   input  wire logic [PID_W-1:0]         lk_pid_i,
   output logic                          lk_hit_o,
   output logic [ENT_W-1:0]              lk_ent_o
);
   localparam int N = LINES * WAYS;
   localparam int IW = $clog2(N);
   logic [N-1:0]       val_reg;
   logic [TAG_W-1:0]   tag_reg [N];
   logic [PID_W-1:0]   pid_reg [N];
   logic [ENT_W-1:0]   ent_reg [N];

   function automatic logic [IW-1:0] idx(input logic [$clog2(LINES)-1:0] l,
                                         input logic [WAY_F_W-1:0] w);
      idx = IW'(l * WAYS + w);
   endfunction

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         val_reg <= '0;
         for (int i = 0; i < N; i++)
         begin
            tag_reg[i] <= '0;
            pid_reg[i] <= '0;
            ent_reg[i] <= '0;
         end
      end
      else if (wr_i)
      begin
         val_reg[idx(wr_line_i, wr_way_i)] <= 1'b1;
         tag_reg[idx(wr_line_i, wr_way_i)] <= wr_tag_i;
         pid_reg[idx(wr_line_i, wr_way_i)] <= wr_pid_i;
         ent_reg[idx(wr_line_i, wr_way_i)] <= wr_ent_i;
      end
   end

   assign rd_tag_o = tag_reg[idx(rd_line_i, rd_way_i)];
   assign rd_pid_o = pid_reg[idx(rd_line_i, rd_way_i)];
   assign rd_ent_o = ent_reg[idx(rd_line_i, rd_way_i)];

   always_comb
   begin
      lk_hit_o = 1'b0;
      lk_ent_o = '0;
      for (int w = 0; w < WAYS; w++)
      begin
         if (val_reg[idx(lk_line_i, WAY_F_W'(w))]
             && tag_reg[idx(lk_line_i, WAY_F_W'(w))] == lk_tag_i
             && (ent_reg[idx(lk_line_i, WAY_F_W'(w))][ENT_G]
                 || pid_reg[idx(lk_line_i, WAY_F_W'(w))] == lk_pid_i))
         begin
            lk_hit_o = 1'b1;
            lk_ent_o = ent_reg[idx(lk_line_i, WAY_F_W'(w))];
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/tea_device.sv
// entry data and misc control registers of the translation buffer
// assumes core holds a request until ack, exceptions are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - entry write stores reg, WE also writes entry
// - target line and way; store vpage, tag
// - each entry write with WE set increments way
// - read trigger loads tag, process tag, entry
// - read selects by line and way
// - selector changes leave loaded fields alone
// - read process tag beats written one
// - spare bits dropped, read zero
// - cacheable flag gates data caching
// - load flag gates loads
// - store flag gates stores
// - execute flag gates fetch
// - global flag skips process tag compare
// - software zeroes unused frame bits
// - WE clear: only register changes
// - hardware sets WE on violation, miss outside an active exception
// - up to 16 ways, unused bits zero
// - process tag 8 to 14 bits
// - software loads process tag before writes
// - double miss flag per exception
// - data access flag per exception
// - bad address flag per exception
// - violation flag per exception
module tea_device
   import tea_pkg::*;
#(
   parameter int LINES = 16,
   parameter int WAYS  = 16,
   parameter int PID_W = 14
)(
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   tea_ctl_if.dev                ctl,
   input  wire logic             exc_valid_i,
   input  wire logic             exc_perm_i,
   input  wire logic             exc_miss_i,
   input  wire logic             exc_dbl_i,
   input  wire logic             exc_bad_i,
   input  wire logic             exc_data_i,
   input  wire logic [VPN_W-1:0] exc_vpage_i,
   input  wire logic             exception_active_i,
   input  wire logic [VPN_W-1:0] lk_vpage_i,
   output logic                  lk_hit_o,
   output logic [PFN_W-1:0]      lk_frame_o,
   output logic                  lk_cacheable_o,
   output logic                  lk_load_ok_o,
   output logic                  lk_store_ok_o,
   output logic                  lk_exec_ok_o
);
   localparam int LINE_W = $clog2(LINES);
   localparam int TAG_W  = VPN_W - LINE_W;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [ENT_W-1:0]   entry_reg;
   logic [VPN_W-1:0]   virtual_page_reg;
   logic [PID_W-1:0]   process_tag_reg;
   logic [WAY_F_W-1:0] way_reg;
   logic               we_reg;
   logic               dbl_reg;
   logic               bad_reg;
   logic               perm_reg;
   logic               d_reg;
   logic               ack_reg;
   logic [DATA_W-1:0]  rdata_reg;

   logic               take;
   logic               wr_entry;
   logic               wr_misc;
   logic               wr_vpage;
   logic               do_write;
   logic               do_read;
   logic               exc_we_set;
   logic [TAG_W-1:0]   rd_tag;
   logic [PID_W-1:0]   rd_pid;
   logic [ENT_W-1:0]   rd_ent;
   logic               lk_hit;
   logic [ENT_W-1:0]   lk_ent;
   logic [DATA_W-1:0]  misc_word;

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   assign take     = ctl.req && !ack_reg;
   assign wr_entry = take && ctl.we && ctl.sel == SEL_ENTRY;
   assign wr_misc  = take && ctl.we && ctl.sel == SEL_MISC;
   assign wr_vpage = take && ctl.we && ctl.sel == SEL_VPAGE;
   assign do_write = wr_entry && we_reg;
   assign do_read  = wr_misc && ctl.wdata[MISC_RD];
   assign exc_we_set = exc_valid_i
                       && (exc_perm_i || (exc_miss_i && !exception_active_i));

   tea_entry_store #(
      .LINES (LINES),
      .WAYS  (WAYS),
      .TAG_W (TAG_W),
      .PID_W (PID_W)
   ) u_store (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .wr_i      (do_write),
      .wr_line_i (virtual_page_reg[LINE_W-1:0]),
      .wr_way_i  (way_reg),
      .wr_tag_i  (virtual_page_reg[VPN_W-1:LINE_W]),
      .wr_pid_i  (process_tag_reg),
      .wr_ent_i  (ctl.wdata[ENT_W-1:0]),
      .rd_line_i (virtual_page_reg[LINE_W-1:0]),
      .rd_way_i  (ctl.wdata[MISC_WAY +: WAY_F_W]),
      .rd_tag_o  (rd_tag),
      .rd_pid_o  (rd_pid),
      .rd_ent_o  (rd_ent),
      .lk_line_i (lk_vpage_i[LINE_W-1:0]),
      .lk_tag_i  (lk_vpage_i[VPN_W-1:LINE_W]),
      .lk_pid_i  (process_tag_reg),
      .lk_hit_o  (lk_hit),
      .lk_ent_o  (lk_ent)
   );

   // ------------------------------------------------------------
   // entry data register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         entry_reg <= '0;
      else if (do_read)
         entry_reg <= rd_ent;
      else if (wr_entry)
         entry_reg <= ctl.wdata[ENT_W-1:0];
   end

   // ------------------------------------------------------------
   // virtual page
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         virtual_page_reg <= '0;
      else if (exc_we_set)
         virtual_page_reg <= exc_vpage_i;
      else if (do_read)
         virtual_page_reg[VPN_W-1:LINE_W] <= rd_tag;
      else if (wr_vpage)
         virtual_page_reg <= ctl.wdata[VPG_LO +: VPN_W];
   end

   // ------------------------------------------------------------
   // misc selector fields
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         way_reg <= '0;
      else if (do_write)
         way_reg <= (way_reg == WAY_F_W'(WAYS - 1)) ? '0
                    : way_reg + 1'b1;
      else if (wr_misc)
         way_reg <= ctl.wdata[MISC_WAY +: WAY_F_W];
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         process_tag_reg <= '0;
      else if (do_read)
         process_tag_reg <= rd_pid;
      else if (wr_misc)
         process_tag_reg <= ctl.wdata[MISC_PID +: PID_W];
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         we_reg <= 1'b0;
      else if (exc_we_set)
         we_reg <= 1'b1;
      else if (wr_misc)
         we_reg <= ctl.wdata[MISC_WE];
   end

   // ------------------------------------------------------------
   // exception flags
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dbl_reg  <= 1'b0;
         bad_reg  <= 1'b0;
         perm_reg <= 1'b0;
         d_reg    <= 1'b0;
      end
      else if (exc_valid_i)
      begin
         dbl_reg  <= exc_dbl_i;
         bad_reg  <= exc_bad_i;
         perm_reg <= exc_perm_i;
         d_reg    <= exc_data_i;
      end
   end

   // ------------------------------------------------------------
   // answer to the core
   // ------------------------------------------------------------
   always_comb
   begin
      misc_word = RESET_WORD;
      misc_word[MISC_WAY +: WAY_F_W] = way_reg;
      misc_word[MISC_WE] = we_reg;
      misc_word[MISC_PID +: PID_W] = process_tag_reg;
      misc_word[MISC_DBL] = dbl_reg;
      misc_word[MISC_BAD] = bad_reg;
      misc_word[MISC_PERM] = perm_reg;
      misc_word[MISC_D] = d_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= '0;
      end
      else
      begin
         ack_reg <= take;
         if (take && !ctl.we)
         begin
            unique case (ctl.sel)
               SEL_ENTRY: rdata_reg <= {7'h00, entry_reg};
               SEL_MISC:  rdata_reg <= misc_word;
               SEL_VPAGE: rdata_reg <= {10'h000, virtual_page_reg, 2'h0};
               default:   rdata_reg <= '0;
            endcase
         end
      end
   end

   assign ctl.ack   = ack_reg;
   assign ctl.rdata = rdata_reg;

   // ------------------------------------------------------------
   // lookup result
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lk_hit_o       <= 1'b0;
         lk_frame_o     <= '0;
         lk_cacheable_o <= 1'b0;
         lk_load_ok_o   <= 1'b0;
         lk_store_ok_o  <= 1'b0;
         lk_exec_ok_o   <= 1'b0;
      end
      else
      begin
         lk_hit_o       <= lk_hit;
         lk_frame_o     <= lk_ent[PFN_W-1:0];
         lk_cacheable_o <= lk_hit && lk_ent[ENT_C];
         lk_load_ok_o   <= lk_hit && lk_ent[ENT_R];
         lk_store_ok_o  <= lk_hit && lk_ent[ENT_W_B];
         lk_exec_ok_o   <= lk_hit && lk_ent[ENT_X];
      end
   end
endmodule
`default_nettype wire

// >>> src/tea_host.sv
// core end: apb registers turned into control reads and writes
// assumes device answers with ack while req is held
`timescale 1ns/1ns
`default_nettype none
module tea_host
   import tea_pkg::*;
#(
   parameter int WAY_USED_W = 4,
   parameter int PID_USED_W = 14,
   parameter int PFN_USED_W = 20
)(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   tea_ctl_if.core          ctl,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b01,
      H_REQ  = 2'b10
   } tea_hstate_t;

   tea_hstate_t       state_reg;
   logic [31:0]       wdata_reg;
   logic [31:0]       rdata_reg;
   logic [31:0]       send_reg;
   logic              we_reg;
   tea_sel_t          sel_reg;
   logic              acc_wr;
   logic              launch;
   logic              mapped;
   logic [31:0]       send_next;

   function automatic logic [31:0] clr_bits(input logic [31:0] v, input int lo,
                                            input int hi);
      clr_bits = v;
      for (int b = 0; b < 32; b++)
         if (b >= lo && b < hi)
            clr_bits[b] = 1'b0;
   endfunction

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign mapped = paddr_i == HOST_CMD || paddr_i == HOST_WDATA
                   || paddr_i == HOST_RDATA || paddr_i == HOST_STAT;
   assign acc_wr = psel_i && penable_i && pwrite_i && mapped;
   assign launch = acc_wr && paddr_i == HOST_CMD && state_reg == H_IDLE;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prdata_o <= '0;
      else if (psel_i && !penable_i)
      begin
         unique case (paddr_i)
            HOST_WDATA: prdata_o <= wdata_reg;
            HOST_RDATA: prdata_o <= rdata_reg;
            HOST_STAT:  prdata_o <= {31'h0000_0000, state_reg == H_REQ};
            default:    prdata_o <= '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wdata_reg <= '0;
      else if (acc_wr && paddr_i == HOST_WDATA)
         wdata_reg <= pwdata_i;
   end

   // ------------------------------------------------------------
   // unused field bits forced to zero
   // ------------------------------------------------------------
   always_comb
   begin
      send_next = wdata_reg;
      if (tea_sel_t'(pwdata_i[1:0]) == SEL_ENTRY)
         send_next = clr_bits(send_next, PFN_USED_W, PFN_W);
      if (tea_sel_t'(pwdata_i[1:0]) == SEL_MISC)
      begin
         send_next = clr_bits(send_next, MISC_WAY + WAY_USED_W, MISC_WAY + WAY_F_W);
         send_next = clr_bits(send_next, MISC_PID + PID_USED_W,
                              MISC_PID + PID_MAX_W);
      end
   end

   // ------------------------------------------------------------
   // request sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= H_IDLE;
         send_reg  <= '0;
         we_reg    <= 1'b0;
         sel_reg   <= SEL_ENTRY;
         rdata_reg <= '0;
      end
      else
      begin
         unique case (state_reg)
            H_IDLE:
               if (launch)
               begin
                  state_reg <= H_REQ;
                  send_reg  <= send_next;
                  we_reg    <= pwdata_i[CMD_WR];
                  sel_reg   <= tea_sel_t'(pwdata_i[1:0]);
               end
            H_REQ:
               if (ctl.ack)
               begin
                  state_reg <= H_IDLE;
                  if (!we_reg)
                     rdata_reg <= ctl.rdata;
               end
            default:
               state_reg <= H_IDLE;
         endcase
      end
   end

   assign ctl.req   = state_reg == H_REQ;
   assign ctl.we    = we_reg;
   assign ctl.sel   = sel_reg;
   assign ctl.wdata = send_reg;
endmodule
`default_nettype wire

// >>> bench/tea_link_monitor.sv
// link checker for the core to entry access handshake
// assumes it watches the interface signals directly, no bind
`timescale 1ns/1ns
`default_nettype none
module tea_link_monitor
   import tea_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              req_i,
   input  wire logic              we_i,
   input  var  tea_sel_t          sel_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              ack_i,
   input  wire logic [DATA_W-1:0] rdata_i
);
   // ------------------------------------------------------------
   // handshake and read word checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   AST_ACK_AFTER_TAKE: assert property (req_i && !ack_i |=> ack_i)
      else $error("ack missing after take");
   AST_ACK_PULSE: assert property (ack_i |=> !ack_i)
      else $error("ack longer than one cycle");
   AST_ACK_HAS_REQ: assert property (ack_i |-> req_i && $past(req_i))
      else $error("ack without request");
   AST_REQ_DROP: assert property (ack_i |=> !req_i)
      else $error("request not dropped after ack");
   AST_REQ_HOLD: assert property (req_i && !ack_i |=> req_i && $stable(we_i)
      && $stable(sel_i) && $stable(wdata_i))
      else $error("request changed before ack");
   AST_SPARE_ZERO: assert property (ack_i && !we_i && sel_i == SEL_ENTRY
      |-> rdata_i[31:25] == 7'h00)
      else $error("spare bits not zero");
   AST_RD_READS_ZERO: assert property (ack_i && !we_i && sel_i == SEL_MISC
      |-> !rdata_i[MISC_RD] && rdata_i[31:24] == 8'h00)
      else $error("read trigger bit not zero");
   AST_RDATA_HOLD: assert property ($changed(rdata_i) |-> ack_i && !we_i)
      else $error("read word changed without read");
   cover property (ack_i && we_i && sel_i == SEL_ENTRY);
   cover property (ack_i && !we_i && sel_i == SEL_MISC);
   cover property (ack_i && !we_i && sel_i == SEL_VPAGE);
endmodule
`default_nettype wire

// >>> bench/tea_device_tb.sv
// bench for host and device ends joined by the control link
// assumes apb slave answers in its own time, one 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tea_device_tb
   import tea_pkg::*;
;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic exc_valid_i, exc_perm_i, exc_miss_i, exc_dbl_i, exc_bad_i, exc_data_i, act;
   logic [19:0] exc_vpage_i, lk_vpage_i, lk_frame_o;
   logic lk_hit_o, lk_c, lk_l, lk_s, lk_x;
   int fails, checked;
   tea_ctl_if u_tea_ctl_if();
   tea_host #(.WAY_USED_W(4), .PID_USED_W(8), .PFN_USED_W(16)) u_tea_host
      (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctl(u_tea_ctl_if.core), .psel_i(psel),
       .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
       .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
   tea_device #(.LINES(16), .WAYS(16), .PID_W(14)) u_tea_device
      (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctl(u_tea_ctl_if.dev), .exc_valid_i(exc_valid_i),
       .exc_perm_i(exc_perm_i), .exc_miss_i(exc_miss_i), .exc_dbl_i(exc_dbl_i),
       .exc_bad_i(exc_bad_i), .exc_data_i(exc_data_i), .exc_vpage_i(exc_vpage_i),
       .exception_active_i(act), .lk_vpage_i(lk_vpage_i), .lk_hit_o(lk_hit_o),
       .lk_frame_o(lk_frame_o), .lk_cacheable_o(lk_c), .lk_load_ok_o(lk_l),
       .lk_store_ok_o(lk_s), .lk_exec_ok_o(lk_x));
   tea_link_monitor u_tea_link_monitor
      (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(u_tea_ctl_if.req), .we_i(u_tea_ctl_if.we),
       .sel_i(u_tea_ctl_if.sel), .wdata_i(u_tea_ctl_if.wdata), .ack_i(u_tea_ctl_if.ack),
       .rdata_i(u_tea_ctl_if.rdata));
   // ------------------------------------------------------------
   // bus and helper tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] mw(logic [3:0] w, logic e, logic [13:0] p, logic [3:0] f);
      return {8'h00, w, 1'b0, e, p, f};
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      begin
         @(posedge clk_i);
         psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
         @(posedge clk_i);
         penable <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_i);
            n++;
         end while (pready !== 1'b1 && n < 50);
         if (n >= 50) fails++;
         r = prdata;
         perr = pslverr;
         psel <= 1'b0; penable <= 1'b0;
      end
   endtask
   task automatic ctl(input logic wr, input tea_sel_t s, input logic [31:0] d);
      logic [31:0] c;
      int n;
      begin
         c = 32'h0000_0000;
         c[CMD_WR] = wr;
         c[1:0] = s;
         apb(1'b1, HOST_WDATA, d, q);
         apb(1'b1, HOST_CMD, c, q);
         n = 0;
         q = 32'h0000_0001;
         while (q[0] !== 1'b0 && n < 20)
         begin
            apb(1'b0, HOST_STAT, 32'h0000_0000, q);
            n++;
         end
         if (n >= 20) fails++;
         apb(1'b0, HOST_RDATA, 32'h0000_0000, q);
      end
   endtask
   task automatic chk_rd(input string nm, input tea_sel_t s, input logic [31:0] e);
      ctl(1'b0, s, 32'h0000_0000);
      `CHK(nm, e, q)
   endtask
   task automatic look(input logic [19:0] p, input logic [4:0] e, input logic [19:0] f);
      lk_vpage_i <= p;
      repeat (2) @(posedge clk_i);
      `CHK("lookup flags", e, {lk_hit_o, lk_c, lk_l, lk_s, lk_x})
      `CHK("lookup frame", f, lk_frame_o)
   endtask
   task automatic exc(input logic [5:0] v, input logic [19:0] p);
      @(posedge clk_i);
      exc_valid_i <= 1'b1;
      exc_perm_i <= v[5];
      exc_miss_i <= v[4];
      exc_dbl_i <= v[3];
      exc_bad_i <= v[2];
      exc_data_i <= v[1];
      act <= v[0];
      exc_vpage_i <= p;
      @(posedge clk_i);
      exc_valid_i <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk_rd("entry reset", SEL_ENTRY, 32'h0000_0000);
      chk_rd("misc reset", SEL_MISC, 32'h0000_0000);
      chk_rd("vpage reset", SEL_VPAGE, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000, q);
      `CHK("unmapped error", 1'b1, perr)
   endtask
   task automatic t_entry_only();
      ctl(1'b1, SEL_ENTRY, 32'hFFFF_FFFF);
      chk_rd("entry word", SEL_ENTRY, 32'h01F0_FFFF);
      look(20'h00000, 5'b00000, 20'h00000);
   endtask
   task automatic t_write();
      ctl(1'b1, SEL_MISC, mw(4'hF, 1'b1, 14'h3FFF, 4'h0));
      chk_rd("misc word", SEL_MISC, mw(4'hF, 1'b1, 14'h00FF, 4'h0));
      ctl(1'b1, SEL_VPAGE, 32'h0000_0044);
      ctl(1'b1, SEL_ENTRY, 32'h0150_0ABC);
      chk_rd("way wrap", SEL_MISC, mw(4'h0, 1'b1, 14'h00FF, 4'h0));
      ctl(1'b1, SEL_VPAGE, 32'h0000_0088);
      ctl(1'b1, SEL_MISC, mw(4'h0, 1'b1, 14'h005A, 4'h0));
      ctl(1'b1, SEL_ENTRY, 32'h00A0_0DEF);
      chk_rd("way step", SEL_MISC, mw(4'h1, 1'b1, 14'h005A, 4'h0));
      look(20'h00011, 5'b11010, 20'h00ABC);
      look(20'h10011, 5'b00000, 20'h00000);
      look(20'h00022, 5'b10101, 20'h00DEF);
      ctl(1'b1, SEL_MISC, mw(4'h1, 1'b0, 14'h0011, 4'h0));
      look(20'h00022, 5'b00000, 20'h00000);
      look(20'h00011, 5'b11010, 20'h00ABC);
   endtask
   task automatic t_read();
      ctl(1'b1, SEL_VPAGE, 32'h003F_FC04);
      ctl(1'b1, SEL_MISC, mw(4'hF, 1'b0, 14'h0022, 4'h0) | 32'h0008_0000);
      chk_rd("misc after read", SEL_MISC, mw(4'hF, 1'b0, 14'h00FF, 4'h0));
      chk_rd("entry after read", SEL_ENTRY, 32'h0150_0ABC);
      chk_rd("vpage after read", SEL_VPAGE, 32'h0000_0044);
      ctl(1'b1, SEL_VPAGE, 32'h0000_0088);
      ctl(1'b1, SEL_MISC, mw(4'h0, 1'b0, 14'h0011, 4'h0));
      chk_rd("entry kept", SEL_ENTRY, 32'h0150_0ABC);
   endtask
   task automatic t_exc();
      exc(6'b100110, 20'h00033);
      chk_rd("misc perm", SEL_MISC, mw(4'h0, 1'b1, 14'h0011, 4'h7));
      chk_rd("vpage perm", SEL_VPAGE, 32'h0000_00CC);
      ctl(1'b1, SEL_MISC, mw(4'h0, 1'b0, 14'h0011, 4'h0));
      exc(6'b011001, 20'h00044);
      chk_rd("misc nested", SEL_MISC, mw(4'h0, 1'b0, 14'h0011, 4'h8));
      chk_rd("vpage nested", SEL_VPAGE, 32'h0000_00CC);
      exc(6'b010000, 20'h00055);
      chk_rd("misc miss", SEL_MISC, mw(4'h0, 1'b1, 14'h0011, 4'h0));
   endtask
   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic final_report();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial
   begin
      #(5000 * 50);
      fails++;
      final_report();
   end
   initial
   begin
      fails = 0; checked = 0; rst_n_i = 1'b0; perr = 1'b0;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
      exc_valid_i = 1'b0; exc_perm_i = 1'b0; exc_miss_i = 1'b0; exc_dbl_i = 1'b0;
      exc_bad_i = 1'b0; exc_data_i = 1'b0; act = 1'b0;
      exc_vpage_i = 20'h00000; lk_vpage_i = 20'h00000;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_entry_only();
      t_write();
      t_read();
      t_exc();
      final_report();
   end
endmodule
`default_nettype wire
